// *** rtl/uart_baud_select_framing_error.sv ***
// baud source selection, tick generation and sticky framing error with axi4-lite registers
// Behaviour
// - mode0 fast: fsys/4, doubled gives fsys/2
// - mode0 compat: fsys/6, doubled gives fsys/3
// - doubling bit at power bit7, reset 0
// - mode2: fsys/32, doubled gives fsys/16
// - mode0 ninth bit set: timer1 overflow/4 or /2
// - modes1,3 timer1: overflow/32 or /16
// - timer1 reload mode: 256-reload with prescale
// - tx/rx clock selects choose timer2 per direction in modes 1 and 3
// - timer2 rollover reloads 16-bit software value
// - timer2 rate fsys/16/(65536-reload)
// - missing stop bit sets framing error
// - control bit7 shows error or mode bit0
// - error flag cleared only by software or reset
// - flag set regardless of view select
module uart_baud_select_framing_error (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write address
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // static timing choice, high selects fast
  input  wire logic                     fast_timing,
  // timer1 overflow pulse from the timer block
  input  wire logic                     timer1_overflow,
  // receiver: sampled stop bit, strobe at stop sample time
  input  wire logic                     rx_stop_strobe,
  input  wire logic                     rx_stop_level,
  // baud ticks toward shifters
  output baud_fe_pkg::baud_ticks_t      ticks,
  // timer2 rollover pulse, for observation
  output logic                          timer2_rollover,
  // interrupt
  output logic                          irq
);

  // software-visible state
  logic [7:0]  serial_control_reg;  // bit7 here is mode bit0 only
  logic [7:0]  power_control_reg;   // doubling and view select
  logic [7:0]  timer2_control_reg;  // tx/rx clock selects
  logic [15:0] timer2_reload_reg;   // high:low reload value
  logic [7:0]  timer1_reload_byte;  // kept for software, rate set by timer1
  logic [3:0]  timer_prescale_field;
  logic        framing_error_flag_reg; // separate from mode bit0
  logic [baud_fe_pkg::IRQ_W-1:0] irq_status_reg;
  logic [baud_fe_pkg::IRQ_W-1:0] irq_mask_reg;

  // decoded controls
  logic       baud_double_bit;
  logic       frame_error_view_select;
  logic       ninth_transmit_bit;
  logic [1:0] serial_mode;
  logic       tx_clock_source_select;
  logic       rx_clock_source_select;
  assign baud_double_bit         = power_control_reg[baud_fe_pkg::PC_BAUD_DOUBLE];
  assign frame_error_view_select = power_control_reg[baud_fe_pkg::PC_FE_VIEW];
  assign ninth_transmit_bit      = serial_control_reg[baud_fe_pkg::SC_NINTH_TX];
  assign serial_mode = {serial_control_reg[baud_fe_pkg::SC_MODE_BIT0],
                        serial_control_reg[baud_fe_pkg::SC_MODE_BIT1]};
  assign tx_clock_source_select  = timer2_control_reg[baud_fe_pkg::T2_TX_CLK];
  assign rx_clock_source_select  = timer2_control_reg[baud_fe_pkg::T2_RX_CLK];

  // ---------------- axi4-lite slave ----------------
  logic        aw_hold, w_hold;      // captured address/data
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;              // both halves present, no pending response
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold     <= 1'b0;
      w_hold      <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold <= 1'b0;
      end
    end
  end

  // write decode; only byte lanes that carry the field take effect
  logic wr_mapped;
  always_comb begin
    case (aw_addr_reg)
      baud_fe_pkg::OFF_SERIAL_CTRL, baud_fe_pkg::OFF_POWER_CTRL,
      baud_fe_pkg::OFF_T2_CTRL, baud_fe_pkg::OFF_T2_RELOAD,
      baud_fe_pkg::OFF_T1_CFG, baud_fe_pkg::OFF_IRQ_STATUS,
      baud_fe_pkg::OFF_IRQ_MASK: wr_mapped = 1'b1;
      default:                   wr_mapped = 1'b0;
    endcase
  end
  logic wr_ok_b0, wr_ok_b1;
  assign wr_ok_b0 = wr_fire && w_strb_reg[0];
  assign wr_ok_b1 = wr_fire && w_strb_reg[1];

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= baud_fe_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? baud_fe_pkg::RESP_OKAY : baud_fe_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; doubling bit resets to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_control_reg   <= baud_fe_pkg::RST_BYTE;
      power_control_reg    <= baud_fe_pkg::RST_BYTE;
      timer2_control_reg   <= baud_fe_pkg::RST_BYTE;
      timer2_reload_reg    <= baud_fe_pkg::RST_RELOAD;
      timer1_reload_byte   <= baud_fe_pkg::RST_BYTE;
      timer_prescale_field <= 4'h0;
      irq_mask_reg         <= '0;
    end else begin
      if (wr_ok_b0) begin
        case (aw_addr_reg)
          // bit7 steers to the flag when view select is set, so mode bit0 is kept
          baud_fe_pkg::OFF_SERIAL_CTRL: begin
            serial_control_reg[6:0] <= w_data_reg[6:0];
            if (!frame_error_view_select)
              serial_control_reg[7] <= w_data_reg[7];
          end
          baud_fe_pkg::OFF_POWER_CTRL: power_control_reg    <= w_data_reg[7:0];
          baud_fe_pkg::OFF_T2_CTRL:    timer2_control_reg   <= w_data_reg[7:0];
          baud_fe_pkg::OFF_T2_RELOAD:  timer2_reload_reg[7:0] <= w_data_reg[7:0];
          baud_fe_pkg::OFF_T1_CFG:     timer1_reload_byte   <= w_data_reg[7:0];
          baud_fe_pkg::OFF_IRQ_MASK:   irq_mask_reg <= w_data_reg[baud_fe_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
      if (wr_ok_b1) begin
        case (aw_addr_reg)
          baud_fe_pkg::OFF_T2_RELOAD: timer2_reload_reg[15:8] <= w_data_reg[15:8];
          baud_fe_pkg::OFF_T1_CFG:
            timer_prescale_field <= w_data_reg[baud_fe_pkg::T1_PRESCALE_LSB +:
                                               baud_fe_pkg::T1_PRESCALE_W];
          default: ;
        endcase
      end
    end
  end

  // ---------------- framing error ----------------
  logic fe_event;   // stop bit sampled low
  assign fe_event = rx_stop_strobe && !rx_stop_level;
  logic fe_sw_clear;  // software writes zero to bit7 while it shows the flag
  assign fe_sw_clear = wr_ok_b0 && aw_addr_reg == baud_fe_pkg::OFF_SERIAL_CTRL &&
                       frame_error_view_select && !w_data_reg[7];

  // sticky flag; set regardless of view select and wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      framing_error_flag_reg <= 1'b0;
    else if (fe_event)
      framing_error_flag_reg <= 1'b1;
    else if (fe_sw_clear)
      framing_error_flag_reg <= 1'b0;
  end

  // interrupt status, write one to clear, event wins
  logic [baud_fe_pkg::IRQ_W-1:0] irq_w1c;
  assign irq_w1c = (wr_ok_b0 && aw_addr_reg == baud_fe_pkg::OFF_IRQ_STATUS) ?
                   w_data_reg[baud_fe_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_status_reg <= '0;
    else begin
      irq_status_reg <= irq_status_reg & ~irq_w1c;
      if (fe_event)
        irq_status_reg[baud_fe_pkg::IRQ_FE] <= 1'b1;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ---------------- axi read ----------------
  logic [31:0] rd_word;
  logic        rd_mapped;
  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      baud_fe_pkg::OFF_SERIAL_CTRL: begin
        rd_word[7:0] = serial_control_reg;
        rd_word[7]   = frame_error_view_select ? framing_error_flag_reg
                                               : serial_control_reg[7];
      end
      baud_fe_pkg::OFF_POWER_CTRL: rd_word[7:0]  = power_control_reg;
      baud_fe_pkg::OFF_T2_CTRL:    rd_word[7:0]  = timer2_control_reg;
      baud_fe_pkg::OFF_T2_RELOAD:  rd_word[15:0] = timer2_reload_reg;
      baud_fe_pkg::OFF_T1_CFG:     rd_word[11:0] = {timer_prescale_field, timer1_reload_byte};
      baud_fe_pkg::OFF_IRQ_STATUS: rd_word[baud_fe_pkg::IRQ_W-1:0] = irq_status_reg;
      baud_fe_pkg::OFF_IRQ_MASK:   rd_word[baud_fe_pkg::IRQ_W-1:0] = irq_mask_reg;
      default:                     rd_mapped = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  // read data registered one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= baud_fe_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? baud_fe_pkg::RESP_OKAY : baud_fe_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- timer2 baud generator ----------------
  // counts sysclks up, rollover reloads; period = 65536 - reload
  logic [15:0] timer2_count_reg;
  logic        t2_running;
  assign t2_running      = tx_clock_source_select || rx_clock_source_select;
  assign timer2_rollover = t2_running && (timer2_count_reg == 16'hFFFF);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      timer2_count_reg <= baud_fe_pkg::RST_RELOAD;
    else if (!t2_running || timer2_rollover)
      timer2_count_reg <= timer2_reload_reg;
    else
      timer2_count_reg <= timer2_count_reg + 16'h0001;
  end

  // ---------------- system clock divider for modes 0 and 2 ----------------
  // fixed divisor; doubling halves it. compat only applies in mode 0
  logic [5:0] sys_div;
  always_comb begin
    if (serial_mode == 2'b00)
      sys_div = fast_timing ? baud_fe_pkg::DIV_M0_FAST
                            : baud_fe_pkg::DIV_M0_COMPAT;
    else
      sys_div = baud_fe_pkg::DIV_M2;
    if (baud_double_bit)
      sys_div = sys_div >> 1;
  end
  logic [5:0] sys_cnt_reg;
  logic       sys_tick;
  assign sys_tick = (sys_cnt_reg >= sys_div - 6'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_tick)
      sys_cnt_reg <= 6'h00;
    else
      sys_cnt_reg <= sys_cnt_reg + 6'h01;
  end

  // ---------------- per-direction source select and divide ----------------
  // timer1 overflow already carries reload/prescale (256-reload)*(prescale+1)
  baud_fe_pkg::baud_src_t src [2];
  logic [1:0] t2_sel;
  assign t2_sel = {rx_clock_source_select, tx_clock_source_select};
  logic [1:0] tick_out;
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dir
      logic [5:0] ovf_div;   // overflows per bit
      logic       ovf_in;    // source pulse
      logic [5:0] cnt_reg;
      logic       hit;
      always_comb begin
        src[d]  = baud_fe_pkg::SRC_SYS_FIXED;
        ovf_div = baud_fe_pkg::DIV_T1_M13;
        ovf_in  = timer1_overflow;
        case (serial_mode)
          2'b00: if (ninth_transmit_bit) begin
            src[d]  = baud_fe_pkg::SRC_TIMER1;
            ovf_div = baud_fe_pkg::DIV_T1_M0;
          end
          2'b01, 2'b11: if (t2_sel[d] && serial_mode != 2'b00) begin
            src[d]  = baud_fe_pkg::SRC_TIMER2;
            ovf_div = baud_fe_pkg::DIV_T2_M13;
            ovf_in  = timer2_rollover;
          end else begin
            src[d]  = baud_fe_pkg::SRC_TIMER1;
          end
          default: ;
        endcase
        // timer2 is never halved by the doubling bit
        if (baud_double_bit && src[d] == baud_fe_pkg::SRC_TIMER1)
          ovf_div = ovf_div >> 1;
      end
      assign hit = ovf_in && (cnt_reg >= ovf_div - 6'h01);
      always_ff @(posedge aclk) begin
        if (!aresetn || src[d] == baud_fe_pkg::SRC_SYS_FIXED)
          cnt_reg <= 6'h00;
        else if (hit)
          cnt_reg <= 6'h00;
        else if (ovf_in)
          cnt_reg <= cnt_reg + 6'h01;
      end
      assign tick_out[d] = (src[d] == baud_fe_pkg::SRC_SYS_FIXED) ? sys_tick : hit;
    end
  endgenerate

  // registered one-cycle ticks
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ticks <= '0;
    else begin
      ticks.tx_tick <= tick_out[0];
      ticks.rx_tick <= tick_out[1];
    end
  end

  // ---------------- assertions ----------------
  property p_fe_sticky;
    @(posedge aclk) disable iff (!aresetn)
      framing_error_flag_reg && !fe_sw_clear |=> framing_error_flag_reg;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("fe flag dropped");

  property p_fe_set;
    @(posedge aclk) disable iff (!aresetn)
      fe_event |=> framing_error_flag_reg && irq_status_reg[baud_fe_pkg::IRQ_FE];
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("fe not set");

  property p_view;
    @(posedge aclk) disable iff (!aresetn)
      frame_error_view_select |-> rd_word[7] == framing_error_flag_reg ||
                                  s_axi_araddr != baud_fe_pkg::OFF_SERIAL_CTRL;
  endproperty
  a_view: assert property (p_view) else $error("bit7 view wrong");

  sequence s_t2_roll;
    timer2_rollover ##1 1'b1;
  endsequence
  property p_t2_reload;
    @(posedge aclk) disable iff (!aresetn)
      s_t2_roll |-> timer2_count_reg == $past(timer2_reload_reg);
  endproperty
  a_t2_reload: assert property (p_t2_reload) else $error("no reload");

  // spacing judged only while the setting holds; a rewrite mid-bit may cut that bit short
  logic m0_fast_cfg;   // mode0, fast, not doubled
  logic m0_compat_cfg; // mode0, compat, doubled
  assign m0_fast_cfg   = serial_mode == 2'b00 && fast_timing && !baud_double_bit &&
                         !ninth_transmit_bit;
  assign m0_compat_cfg = serial_mode == 2'b00 && !fast_timing && baud_double_bit;
  property p_m0_fast;
    @(posedge aclk) disable iff (!aresetn)
      m0_fast_cfg && sys_tick |=> (!sys_tick || !m0_fast_cfg) [*3];
  endproperty
  a_m0_fast: assert property (p_m0_fast) else $error("mode0 fast spacing");

  property p_m0_compat;
    @(posedge aclk) disable iff (!aresetn)
      m0_compat_cfg && sys_tick |=> (!sys_tick || !m0_compat_cfg) [*2];
  endproperty
  a_m0_compat: assert property (p_m0_compat) else $error("compat spacing");

  property p_double_reset;
    @(posedge aclk) !aresetn |=> !baud_double_bit;
  endproperty
  a_double_reset: assert property (p_double_reset) else $error("double bit reset");

  property p_m2_div;
    @(posedge aclk) disable iff (!aresetn)
      serial_mode == 2'b10 |-> sys_div == (baud_double_bit ? 6'h10 : 6'h20);
  endproperty
  a_m2_div: assert property (p_m2_div) else $error("mode2 divisor");

  property p_tick_pulse;
    @(posedge aclk) disable iff (!aresetn)
      ticks.tx_tick && src[0] != baud_fe_pkg::SRC_SYS_FIXED |=> !ticks.tx_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");

endmodule // uart_baud_select_framing_error

// *** common/baud_fe_pkg.sv ***
// package: register map, field positions and constants for baud select and framing error block
package baud_fe_pkg;

  // axi4-lite register byte offsets
  localparam logic [7:0] OFF_SERIAL_CTRL = 8'h00; // serial_control_reg image
  localparam logic [7:0] OFF_POWER_CTRL  = 8'h04; // power_control_reg image
  localparam logic [7:0] OFF_T2_CTRL     = 8'h08; // timer2_control_reg image
  localparam logic [7:0] OFF_T2_RELOAD   = 8'h0C; // timer2_reload_high:low
  localparam logic [7:0] OFF_T1_CFG      = 8'h10; // timer1 reload byte and prescale
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h14; // sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h18; // interrupt enables

  // serial control fields
  localparam int SC_MODE_BIT0 = 7; // shared with framing error view
  localparam int SC_MODE_BIT1 = 6;
  localparam int SC_NINTH_TX  = 3;
  // power control fields
  localparam int PC_BAUD_DOUBLE = 7;
  localparam int PC_FE_VIEW     = 6;
  // timer2 control fields
  localparam int T2_RX_CLK = 5;
  localparam int T2_TX_CLK = 4;
  // timer1 config fields
  localparam int T1_PRESCALE_LSB = 8;
  localparam int T1_PRESCALE_W   = 4;

  // interrupt status bits
  localparam int IRQ_FE = 0;
  localparam int IRQ_W  = 1;

  // fixed divisors per bit: system clocks, timer1 overflows (mode 0 with ninth bit, modes 1 and 3) or timer2 rollovers
  localparam logic [5:0] DIV_M0_FAST   = 6'h04;
  localparam logic [5:0] DIV_M0_COMPAT = 6'h06;
  localparam logic [5:0] DIV_M2        = 6'h20;
  localparam logic [5:0] DIV_T1_M0     = 6'h04; // overflows per mode-0 bit
  localparam logic [5:0] DIV_T1_M13    = 6'h20; // overflows per mode-1/3 bit
  localparam logic [5:0] DIV_T2_M13    = 6'h10; // rollovers per mode-1/3 bit

  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // selected source for one direction
  typedef enum logic [1:0] {
    SRC_SYS_FIXED = 2'b00,
    SRC_TIMER1    = 2'b01,
    SRC_TIMER2    = 2'b10
  } baud_src_t;

  // ticks produced toward the shifters
  typedef struct packed {
    logic tx_tick;
    logic rx_tick;
  } baud_ticks_t;

endpackage

// *** test/remote_serial_model.sv ***
// far-side model: timer1 overflow source and receiver stop-bit samples
module remote_serial_model #(
  parameter logic [7:0] RELOAD   = 8'hFD, // timer1 reload byte
  parameter int         PRESCALE = 0      // timer1 prescale field
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // toward the block
  output logic      timer1_overflow,
  output logic      rx_stop_strobe,
  output logic      rx_stop_level
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PERIOD = (256 - RELOAD) * (PRESCALE + 1);
  int ovf_cnt_reg; // clocks since last overflow

  // auto-reload overflow, one cycle wide; feeds baud logic only, no timer1 interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_cnt_reg     <= 0;
      timer1_overflow <= 1'b0;
    end else if (ovf_cnt_reg == PERIOD - 1) begin
      ovf_cnt_reg     <= 0;
      timer1_overflow <= 1'b1;
    end else begin
      ovf_cnt_reg     <= ovf_cnt_reg + 1;
      timer1_overflow <= 1'b0;
    end
  end

  // line starts high before the first frame
  initial begin
    rx_stop_strobe = 1'b0;
    rx_stop_level  = 1'b1;
  end

  // one stop sample; level inverted after so a stale value never looks valid
  task automatic send_frame(input logic stop);
    rx_stop_level  <= stop;
    rx_stop_strobe <= 1'b1;
    @(posedge aclk);
    rx_stop_strobe <= 1'b0;
    rx_stop_level  <= ~stop;
  endtask
endmodule // remote_serial_model

// *** test/uart_baud_select_framing_error_tb.sv ***
// testbench for baud selection and framing error block
module uart_baud_select_framing_error_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // pins
  logic        aclk, aresetn, fast_timing, timer2_rollover, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        timer1_overflow, rx_stop_strobe, rx_stop_level;
  baud_fe_pkg::baud_ticks_t ticks;
  int          num_errors, check_count;

  uart_baud_select_framing_error dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fast_timing(fast_timing),
    .timer1_overflow(timer1_overflow), .rx_stop_strobe(rx_stop_strobe),
    .rx_stop_level(rx_stop_level), .ticks(ticks), .timer2_rollover(timer2_rollover), .irq(irq));

  // overflow every 3 clocks
  remote_serial_model partner_u (
    .aclk(aclk), .aresetn(aresetn), .timer1_overflow(timer1_overflow),
    .rx_stop_strobe(rx_stop_strobe), .rx_stop_level(rx_stop_level));

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // write; handshakes judged at negedge, so no race with the edge's own updates
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(negedge aclk);
      ta  = s_axi_awvalid && s_axi_awready;
      tw  = s_axi_wvalid && s_axi_wready;
      tb  = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
  endtask

  // read; bready and rready stay high throughout
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta  = s_axi_arvalid && s_axi_arready;
      tr  = s_axi_rvalid;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
  endtask

  function automatic logic sig(input int s);
    return s == 0 ? ticks.tx_tick : s == 1 ? ticks.rx_tick : timer2_rollover;
  endfunction

  // skip two pulses (old setting may linger), then time the next gap
  task automatic per(input int s, input int e);
    int n;
    for (int k = 0; k < 2; k++) begin
      do @(negedge aclk); while (sig(s) !== 1'b1);
    end
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (sig(s) !== 1'b1);
    chk(n, e);
    @(posedge aclk);
  endtask

  // reset value and unmapped place
  task automatic reset_and_map();
    rd(baud_fe_pkg::OFF_POWER_CTRL);
    chk(rdv, 32'h00000000);
    rd(8'h1C);
    chk(rsp, baud_fe_pkg::RESP_SLVERR);
    chk(rdv, 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF);
    chk(rsp, baud_fe_pkg::RESP_SLVERR);
  endtask

  // fixed and timer1 rates: {fast, serial ctrl, power ctrl, clocks per tick}
  task automatic rates();
    logic [31:0] tbl [12] = '{32'h01000004, 32'h01008002, 32'h00000006, 32'h00008003,
      32'h01800020, 32'h01808010, 32'h0108000C, 32'h01088006, 32'h0008000C,
      32'h01400060, 32'h01408030, 32'h01C00060};
    foreach (tbl[i]) begin
      fast_timing <= tbl[i][24];
      wr(baud_fe_pkg::OFF_SERIAL_CTRL, {24'h0, tbl[i][23:16]});
      wr(baud_fe_pkg::OFF_POWER_CTRL, {24'h0, tbl[i][15:8]});
      per(0, tbl[i][7:0]);
    end
  endtask

  // timer2 per direction, reload FFFE gives a two-clock rollover
  task automatic timer2_split();
    wr(baud_fe_pkg::OFF_SERIAL_CTRL, 32'h40);
    wr(baud_fe_pkg::OFF_POWER_CTRL, 32'h00);
    wr(baud_fe_pkg::OFF_T2_RELOAD, 32'hFFFE);
    wr(baud_fe_pkg::OFF_T2_CTRL, 32'h20);
    per(2, 2);
    per(1, 32);
    per(0, 96);
    wr(baud_fe_pkg::OFF_POWER_CTRL, 32'h80);
    wr(baud_fe_pkg::OFF_T2_CTRL, 32'h10);
    per(0, 32);
    per(1, 48);
  endtask

  // sticky flag, shared view bit, interrupt mask and clear
  task automatic framing();
    wr(baud_fe_pkg::OFF_IRQ_MASK, 32'h1);
    chk(rsp, baud_fe_pkg::RESP_OKAY);
    wr(baud_fe_pkg::OFF_SERIAL_CTRL, 32'h00);
    wr(baud_fe_pkg::OFF_POWER_CTRL, 32'h00);
    partner_u.send_frame(1'b1);
    rd(baud_fe_pkg::OFF_IRQ_STATUS);
    chk(rdv, 32'h0);
    partner_u.send_frame(1'b0);
    rd(baud_fe_pkg::OFF_IRQ_STATUS);
    chk(irq, 1'b1);
    chk(rdv, 32'h1);
    rd(baud_fe_pkg::OFF_SERIAL_CTRL);
    chk(rdv, 32'h00);
    wr(baud_fe_pkg::OFF_POWER_CTRL, 32'h40);
    rd(baud_fe_pkg::OFF_SERIAL_CTRL);
    chk(rdv, 32'h80);
    wr(baud_fe_pkg::OFF_SERIAL_CTRL, 32'h80);
    rd(baud_fe_pkg::OFF_SERIAL_CTRL);
    chk(rdv, 32'h80);
    wr(baud_fe_pkg::OFF_SERIAL_CTRL, 32'h00);
    rd(baud_fe_pkg::OFF_SERIAL_CTRL);
    chk(rdv, 32'h00);
    wr(baud_fe_pkg::OFF_IRQ_STATUS, 32'h1);
    rd(baud_fe_pkg::OFF_IRQ_STATUS);
    chk(irq, 1'b0);
    chk(rdv, 32'h0);
    wr(baud_fe_pkg::OFF_IRQ_MASK, 32'h0);
    partner_u.send_frame(1'b0);
    rd(baud_fe_pkg::OFF_IRQ_STATUS);
    chk(irq, 1'b0);
    chk(rdv, 32'h1);
  endtask

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {fast_timing, s_axi_bready, s_axi_rready} = 3'h7;
    s_axi_wstrb = 4'hF;
    num_errors  = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_and_map();
    rates();
    timer2_split();
    framing();
    final_report();
  end

  // a stalled handshake or missing tick ends the run here
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    final_report();
  end
endmodule // uart_baud_select_framing_error_tb
